// [pcpm_defines.svh]
// Constants for the upper port pin multiplexer: register offsets, reset values, field positions.
// Assumes inclusion by pcpm_pkg and the design modules; definitions only.
`ifndef PCPM_DEFINES_SVH
`define PCPM_DEFINES_SVH

// ****************************************************************
// Register byte offsets on the APB slave
// ****************************************************************
`define PCPM_OFF_PIN_LEVELS  12'h000
`define PCPM_OFF_LATCH       12'h004
`define PCPM_OFF_DIRECTION   12'h008
`define PCPM_OFF_PERIPH_CTRL 12'h00C

// ****************************************************************
// Reset values
// ****************************************************************
`define PCPM_RST_LATCH       8'h00
`define PCPM_RST_DIRECTION   8'hFF
`define PCPM_RST_PERIPH_CTRL 8'h00

// ****************************************************************
// Peripheral control register field positions
// ****************************************************************
`define PCPM_CTL_SPI_EN      0
`define PCPM_CTL_SPI_MASTER  1
`define PCPM_CTL_I2C_EN      2
`define PCPM_CTL_SMBUS       3
`define PCPM_CTL_USART_EN    4
`define PCPM_CTL_USART_SYNC  5
`define PCPM_CTL_USART_MSTR  6
`define PCPM_CTL_USART_TXEN  7

`endif

// [pcpm_pkg.sv]
// Types shared by the upper port pin multiplexer files.
// Assumes pcpm_defines.svh is reachable by bare name.
`include "pcpm_defines.svh"

package pcpm_pkg;

   // ****************************************************************
   // Peripheral mode selection
   // ****************************************************************
   typedef struct packed {
      logic usart_txen;
      logic usart_mstr;
      logic usart_sync;
      logic usart_en;
      logic smbus;
      logic i2c_en;
      logic spi_master;
      logic spi_en;
   } pcpm_ctrl_t;

   // Signals that the serial peripherals offer to the pins.
   typedef struct packed {
      logic spi_clock_out;
      logic spi_data_out;
      logic i2c_clock_out;
      logic i2c_data_out;
      logic usart_tx;
      logic usart_sync_clock_out;
      logic usart_sync_data_out;
   } pcpm_periph_out_t;

   // Signals that the pins deliver to the serial peripherals.
   typedef struct packed {
      logic spi_clock_in;
      logic spi_data_in;
      logic i2c_clock_in;
      logic i2c_data_in;
      logic i2c_smbus_levels;
      logic usart_rx;
      logic usart_sync_clock_in;
      logic usart_sync_data_in;
   } pcpm_periph_in_t;

   typedef enum logic [2:0] {
      PCPM_APB_IDLE   = 3'b001,
      PCPM_APB_SETUP  = 3'b010,
      PCPM_APB_ACCESS = 3'b100
   } pcpm_apb_state_t;

endpackage : pcpm_pkg

// [pcpm_pin_mux.sv]
// Combinational override logic for pins 3 to 7 of the port.
// Assumes registered direction, latch and mode inputs from the top module.
`timescale 1ns/1ps

module pcpm_pin_mux
   import pcpm_pkg::*;
(
   // Configuration
   input  wire pcpm_ctrl_t       ctrl,
   input  wire logic [7:0]       dir,
   input  wire logic [7:0]       lat,
   // Peripheral side
   input  wire pcpm_periph_out_t pout,
   // Pin side
   output logic [7:0]            pin_o,
   output logic [7:0]            pin_oe
);

   always_comb begin
      // Plain port behaviour when no function owns the pin.
      pin_o  = lat;
      pin_oe = ~dir;
      // Clock pin: SPI master or I2C drives, SPI slave reads the clock.
      if (ctrl.i2c_en) begin
         if (!dir[3]) begin
            pin_o[3]  = pout.i2c_clock_out;
            pin_oe[3] = 1'b1;
         end
         // I2C data owns pin 4 even though its direction stays 1.
         pin_o[4]  = pout.i2c_data_out;
         pin_oe[4] = ~pout.i2c_data_out;
      end else if (ctrl.spi_en) begin
         if (!dir[3] && ctrl.spi_master) begin
            pin_o[3] = pout.spi_clock_out;
         end
         if (!dir[5]) begin
            pin_o[5] = pout.spi_data_out;
         end
      end
      // Transmit and synchronous clock override direction.
      if (ctrl.usart_en) begin
         if (!ctrl.usart_sync) begin
            pin_o[6]  = pout.usart_tx;
            pin_oe[6] = 1'b1;
         end else begin
            if (ctrl.usart_mstr) begin
               pin_o[6]  = pout.usart_sync_clock_out;
               pin_oe[6] = 1'b1;
            end
            if (ctrl.usart_txen) begin
               pin_o[7]  = pout.usart_sync_data_out;
               pin_oe[7] = 1'b1;
            end
         end
      end
   end

endmodule : pcpm_pin_mux

// [pcpm_port_c_upper.sv]
// Top of the upper port pin multiplexer: APB registers, pin sampling and peripheral routing.
// Assumes synchronous pin inputs and an APB master on pclk.
//
// How it works
// - Direction 0 drives latch bit onto pin; direction 1 floats the pin.
// - After reset every pin is an input.
// - Direction register reads back stored bits despite peripheral overrides.
// - Latch register reads and writes the latch, not pin levels.
// - SPI slave with direction 1 passes pin 3 clock to serial module.
// - I2C with direction 0 drives module clock on pin 3.
// - I2C clock input buffer type follows I2C or SMBus setting.
// - Pin 4 with direction 1 feeds SPI data in.
// - I2C drives data on pin 4 while direction stays 1.
// - I2C data input buffer type follows I2C or SMBus setting.
// - SPI with direction 0 drives SPI data out on pin 5.
// - Asynchronous transmit drives pin 6 over port data.
// - Synchronous master drives USART clock on pin 6.
// - Synchronous slave takes external clock from pin 6.
// - Pin 7 supplies asynchronous receive data.
// - Synchronous transmit drives data on pin 7.
// - Synchronous receive takes data from pin 7.
// - Don't-care direction is overridden by the active function.
// - Second capture channel uses pin 1 when select set, else second port bit 3.
`timescale 1ns/1ps

module pcpm_port_c_upper
   import pcpm_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic                   pready,
   output logic      [31:0]       prdata,
   output logic                   pslverr,
   // Port pins
   input  wire logic [7:0]        pin_i,
   output logic      [7:0]        pin_o,
   output logic      [7:0]        pin_oe,
   // Serial peripherals
   input  wire pcpm_periph_out_t  periph_out,
   output pcpm_periph_in_t        periph_in,
   // Second capture/compare channel
   input  wire logic              second_capture_pin_select,
   input  wire logic              second_port_bit_3_i,
   input  wire logic              second_capture_compare_out,
   input  wire logic              second_capture_compare_out_en,
   output logic                   second_capture_compare_capture_in,
   output logic                   second_capture_compare_on_port_pin_1,
   output logic                   second_capture_compare_port_b_o,
   output logic                   second_capture_compare_port_b_oe
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0]      lat_reg;
   logic [7:0]      dir_reg;
   pcpm_ctrl_t      ctrl_reg;
   logic [7:0]      pins_reg;
   logic            sel_reg;
   logic [7:0]      mux_o;
   logic [7:0]      mux_oe;
   logic            wr_en;
   logic            rd_en;
   logic            addr_ok;
   logic [31:0]     rd_next;

   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
      merge_byte = s[0] ? d[7:0] : old;
   endfunction : merge_byte

   // A write lands at the edge at which the master samples pready high, never earlier.
   assign wr_en = psel && penable && pwrite && pready;
   assign rd_en = psel && penable && !pwrite && !pready;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   always_comb begin
      addr_ok = 1'b1;
      rd_next = 32'h0000_0000;
      if (paddr == `PCPM_OFF_PIN_LEVELS) begin
         rd_next[7:0] = pins_reg;
      end else if (paddr == `PCPM_OFF_LATCH) begin
         rd_next[7:0] = lat_reg;
      end else if (paddr == `PCPM_OFF_DIRECTION) begin
         rd_next[7:0] = dir_reg;
      end else if (paddr == `PCPM_OFF_PERIPH_CTRL) begin
         rd_next[7:0] = ctrl_reg;
      end else begin
         addr_ok = 1'b0;
      end
   end

   // ****************************************************************
   // APB handshake: one wait state, answer on the second access cycle
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !addr_ok;
         if (rd_en) begin
            prdata <= addr_ok ? rd_next : 32'h0000_0000;
         end
      end
   end

   // Writes to the pin-level address land in the latch.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_reg <= `PCPM_RST_LATCH;
      end else if (wr_en && (paddr == `PCPM_OFF_LATCH || paddr == `PCPM_OFF_PIN_LEVELS)) begin
         lat_reg <= merge_byte(lat_reg, pwdata, pstrb);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_reg <= `PCPM_RST_DIRECTION;
      end else if (wr_en && paddr == `PCPM_OFF_DIRECTION) begin
         dir_reg <= merge_byte(dir_reg, pwdata, pstrb);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `PCPM_RST_PERIPH_CTRL;
      end else if (wr_en && paddr == `PCPM_OFF_PERIPH_CTRL) begin
         ctrl_reg <= merge_byte(ctrl_reg, pwdata, pstrb);
      end
   end

   // Configuration bit is resampled on every clock after reset release; reset selects pin 1.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_reg <= 1'b1;
      end else begin
         sel_reg <= second_capture_pin_select;
      end
   end

   // ****************************************************************
   // Pin drive and sampling
   // ****************************************************************
   pcpm_pin_mux u_mux (
      .ctrl   (ctrl_reg),
      .dir    (dir_reg),
      .lat    (lat_reg),
      .pout   (periph_out),
      .pin_o  (mux_o),
      .pin_oe (mux_oe)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_o    <= 8'h00;
         pin_oe   <= 8'h00;
         pins_reg <= 8'h00;
      end else begin
         pin_o    <= mux_o;
         pin_oe   <= mux_oe;
         pins_reg <= pin_i;
         // Pin 1 carries the compare output when selected.
         if (sel_reg && second_capture_compare_out_en && !dir_reg[1]) begin
            pin_o[1]  <= second_capture_compare_out;
            pin_oe[1] <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Inputs routed to the peripherals
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_in          <= '0;
         second_capture_compare_capture_in    <= 1'b0;
         second_capture_compare_on_port_pin_1 <= 1'b1;
         second_capture_compare_port_b_o      <= 1'b0;
         second_capture_compare_port_b_oe     <= 1'b0;
      end else begin
         periph_in.spi_clock_in        <= dir_reg[3] ? pin_i[3] : 1'b0;
         periph_in.spi_data_in         <= dir_reg[4] ? pin_i[4] : 1'b0;
         periph_in.i2c_clock_in        <= pin_i[3];
         periph_in.i2c_data_in         <= pin_i[4];
         periph_in.i2c_smbus_levels    <= ctrl_reg.i2c_en & ctrl_reg.smbus;
         periph_in.usart_rx            <= dir_reg[7] ? pin_i[7] : 1'b1;
         periph_in.usart_sync_clock_in <= dir_reg[6] ? pin_i[6] : 1'b0;
         periph_in.usart_sync_data_in  <= dir_reg[7] ? pin_i[7] : 1'b0;
         second_capture_compare_on_port_pin_1            <= sel_reg;
         second_capture_compare_capture_in               <= sel_reg ? pin_i[1] : second_port_bit_3_i;
         second_capture_compare_port_b_o                 <= second_capture_compare_out;
         second_capture_compare_port_b_oe                <= !sel_reg && second_capture_compare_out_en;
      end
   end

endmodule : pcpm_port_c_upper

// [pcpm_board_model.sv]
// Board side of the port: resolves each pin from the design driver and an external level.
// Assumes the testbench sets the external levels that the board applies to undriven pins.
`timescale 1ns/1ps

module pcpm_board_model (
   // Design side
   input  wire logic [7:0] pin_o,
   input  wire logic [7:0] pin_oe,
   // Board side
   input  wire logic [7:0] ext,
   output logic      [7:0] pin_i
);
   // ****************************************************************
   // Pin resolution
   // ****************************************************************
   // A driven pin shows the design level; a floating pin shows the board level.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_i[i] = pin_oe[i] ? pin_o[i] : ext[i];
      end
   end
endmodule : pcpm_board_model

// [pcpm_port_c_upper_asserts.sv]
// Concurrent checks on the ports of the upper port pin multiplexer.
// Assumes binding to pcpm_port_c_upper, one clock and active-low reset.
`timescale 1ns/1ps

module pcpm_port_c_upper_asserts
   import pcpm_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   // Pins
   input  wire logic [7:0]  pin_oe
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   assign acc = psel && penable && !pready;
   ready_answer_a: assert property (acc |-> ##[1:2] pready) else $error("no ready");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
   unmapped_err_a: assert property (acc && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C})
      |-> ##[1:2] (pready && pslverr)) else $error("unmapped accepted");
   rdata_upper_a: assert property (prdata[31:8] == 24'h000000) else $error("upper read bits");
   reset_input_a: assert property ($rose(presetn) |-> pin_oe == 8'h00) else $error("pin driven");
   plain_dir_a: assert property (!$stable({pin_oe[2], pin_oe[0]})
      |-> $past(psel && pwrite, 1) || $past(psel && pwrite, 2)) else $error("oe moved");
   mapped_ok_a: assert property (acc && paddr == 12'h008 |-> ##[1:2] (pready && !pslverr))
      else $error("mapped refused");
   wr_cov: cover property (psel && penable && pready && pwrite);
   rd_cov: cover property (psel && penable && pready && !pwrite);
   err_cov: cover property (pslverr);
endmodule : pcpm_port_c_upper_asserts

bind pcpm_port_c_upper pcpm_port_c_upper_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .pin_oe(pin_oe));

// [port_c_upper_pin_mux_tb.sv]
// Self-checking bench for the upper port pin multiplexer.
// Assumes the design files, the board model and the checker are compiled before it.
`timescale 1ns/1ps
`include "pcpm_defines.svh"

module port_c_upper_pin_mux_tb
   import pcpm_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, re, sel, b3, cout, cen, cap, onp1, bo, boe, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [3:0] pstrb;
   logic [7:0] pin_i, pin_o, pin_oe, ext;
   pcpm_periph_out_t po;
   pcpm_periph_in_t pi;
   int err_count, n_tests;

   pcpm_port_c_upper uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .periph_out(po), .periph_in(pi),
      .second_capture_pin_select(sel), .second_port_bit_3_i(b3), .second_capture_compare_out(cout), .second_capture_compare_out_en(cen),
      .second_capture_compare_capture_in(cap), .second_capture_compare_on_port_pin_1(onp1), .second_capture_compare_port_b_o(bo), .second_capture_compare_port_b_oe(boe));
   pcpm_board_model board (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext), .pin_i(pin_i));

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task final_report;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 50) chk(1'b0, 1'b1);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : acc

   task cfg(input logic [7:0] c, input logic [7:0] dr, input logic [7:0] l);
      acc(1'b1, `PCPM_OFF_PERIPH_CTRL, {24'h000000, c});
      acc(1'b1, `PCPM_OFF_DIRECTION, {24'h000000, dr});
      acc(1'b1, `PCPM_OFF_LATCH, {24'h000000, l});
      repeat (3) @(posedge pclk);
   endtask : cfg

   // ****************************************************************
   // Clock, watchdog and tests
   // ****************************************************************
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      final_report();
   end

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      pstrb = 4'hF; ext = 8'h00; po = '0; sel = 1'b1; b3 = 1'b0; cout = 1'b0; cen = 1'b0;
      err_count = 0; n_tests = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      acc(1'b0, `PCPM_OFF_DIRECTION, 32'h0);
      chk(rv, 32'h000000FF);
      chk(pin_oe, 8'h00);
      cfg(8'h00, 8'h00, 8'hA5);
      chk({pin_oe, pin_o}, 16'hFFA5);
      cfg(8'h00, 8'hF0, 8'hA5);
      ext <= 8'h3C;
      acc(1'b0, `PCPM_OFF_PIN_LEVELS, 32'h0);
      chk(rv, 32'h00000035);
      chk(pin_oe, 8'h0F);
      acc(1'b0, `PCPM_OFF_LATCH, 32'h0);
      chk(rv, 32'h000000A5);
      // A write with byte lane 0 switched off must leave the latch alone.
      pstrb <= 4'h0;
      acc(1'b1, `PCPM_OFF_LATCH, 32'h000000FF);
      pstrb <= 4'hF;
      acc(1'b0, `PCPM_OFF_LATCH, 32'h0);
      chk(rv, 32'h000000A5);
      acc(1'b0, 12'h010, 32'h0);
      chk(re, 1'b1);
      chk(rv, 32'h00000000);
      po <= '{i2c_clock_out: 1'b1, default: 1'b0};
      cfg(8'h0C, 8'hF7, 8'h00);
      chk({pin_oe[4:3], pin_o[4:3]}, 4'b1101);
      chk({pi.i2c_clock_in, pi.i2c_data_in}, 2'b10);
      chk(pi.i2c_smbus_levels, 1'b1);
      acc(1'b0, `PCPM_OFF_DIRECTION, 32'h0);
      chk(rv, 32'h000000F7);
      po <= '{spi_data_out: 1'b1, default: 1'b0};
      cfg(8'h01, 8'hDF, 8'h00);
      for (int k = 0; k < 2; k++) begin
         ext <= k ? 8'h00 : 8'h18;
         repeat (3) @(posedge pclk);
         chk({pi.spi_clock_in, pi.spi_data_in}, k ? 2'b00 : 2'b11);
      end
      chk({pin_oe[5], pin_o[5]}, 2'b11);
      po <= '{usart_tx: 1'b1, default: 1'b0};
      ext <= 8'h00;
      cfg(8'h10, 8'hFF, 8'h00);
      chk({pin_oe[6], pin_o[6], pi.usart_rx}, 3'b110);
      po <= '{usart_sync_clock_out: 1'b1, usart_sync_data_out: 1'b1, default: 1'b0};
      cfg(8'hF0, 8'hFF, 8'h00);
      chk({pin_oe[7:6], pin_o[7:6]}, 4'hF);
      ext <= 8'hC0;
      cfg(8'h30, 8'hFF, 8'h00);
      chk({pin_oe[7:6], pi.usart_sync_clock_in, pi.usart_sync_data_in}, 4'b0011);
      cen <= 1'b1;
      cout <= 1'b1;
      cfg(8'h00, 8'hFD, 8'h00);
      chk({pin_oe[1], pin_o[1], onp1}, 3'b111);
      sel <= 1'b0;
      b3 <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({onp1, cap}, 2'b01);
      chk({bo, boe}, 2'b11);
      final_report();
   end
endmodule : port_c_upper_pin_mux_tb
